/* File: cfa_pkg.sv */
// shared constants and types for the flag and operand address block
package cfa_pkg;

  // register byte addresses
  localparam logic [7:0] A_FLAGS = 8'h00;
  localparam logic [7:0] A_OPERAND = 8'h04;
  localparam logic [7:0] A_COMMAND = 8'h08;
  localparam logic [7:0] A_RESULT = 8'h0C;
  localparam logic [7:0] A_PC = 8'h10;
  localparam logic [7:0] A_FETCH = 8'h14;
  localparam logic [7:0] A_ADDR = 8'h18;
  localparam logic [7:0] A_TARGET = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;

  // flag bit positions
  localparam int FB_V = 7;
  localparam int FB_H = 4;
  localparam int FB_I = 3;
  localparam int FB_N = 2;
  localparam int FB_Z = 1;
  localparam int FB_C = 0;
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RST = 8'h68;

  // fetch register fields
  localparam int FF_SRC = 16;
  localparam int FF_DST = 20;
  localparam int FF_COND = 24;
  localparam int FF_CSEL = 25;

  // instruction lengths in bytes
  localparam logic [15:0] LEN1 = 16'h0001;
  localparam logic [15:0] LEN2 = 16'h0002;
  localparam logic [15:0] LEN3 = 16'h0003;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP, OP_AND, OP_ORA, OP_EOR,
    OP_LD8, OP_LD16, OP_DAA, OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_BTST,
    OP_CLC, OP_SEC, OP_CLI, OP_SEI, OP_TAP, OP_TPA, OP_NOP
  } cfa_op_e;

  typedef enum logic [2:0] {
    register_operand_mode, pc_offset_mode, inline_operand_mode, inline_wide_mode,
    page_zero_mode, full_address_mode, page_zero_branch_mode
  } cfa_mode_e;

  typedef enum logic [0:0] {SV_RUN, SV_STACKING} cfa_sv_e;

endpackage

/* File: cfa_flag_alu.sv */
// result and condition flag generation for one operation
`timescale 1ns/1ps
module cfa_flag_alu (
  input wire cfa_pkg::cfa_op_e op, // operation
  input wire logic [7:0] a, // accumulator operand
  input wire logic [7:0] b, // second operand
  input wire logic [15:0] wide, // 16-bit load value
  input wire logic [7:0] flags_in, // flags before
  output logic [15:0] result, // result value
  output logic [7:0] flags_out // flags after
);
  logic [8:0] s;
  logic [4:0] hs;
  logic [7:0] r;
  logic [7:0] f;
  logic cin;
  logic cf;
  logic [7:0] corr;

  always_comb begin
    f = flags_in;
    r = a;
    s = 9'h000;
    hs = 5'h00;
    corr = 8'h00;
    cf = 1'b0;
    cin = (op == cfa_pkg::OP_ADC || op == cfa_pkg::OP_SBC) ? flags_in[cfa_pkg::FB_C] : 1'b0;
    result = {8'h00, a};
    unique case (op)
      cfa_pkg::OP_ADD, cfa_pkg::OP_ADC: begin
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        r = s[7:0];
        f[cfa_pkg::FB_H] = hs[4];
        f[cfa_pkg::FB_C] = s[8];
        f[cfa_pkg::FB_V] = (a[7] == b[7]) && (r[7] != a[7]);
      end
      cfa_pkg::OP_SUB, cfa_pkg::OP_SBC, cfa_pkg::OP_CMP: begin
        s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        r = s[7:0];
        f[cfa_pkg::FB_C] = s[8];
        f[cfa_pkg::FB_V] = (a[7] != b[7]) && (r[7] != a[7]);
      end
      cfa_pkg::OP_AND, cfa_pkg::OP_ORA, cfa_pkg::OP_EOR, cfa_pkg::OP_LD8: begin
        r = (op == cfa_pkg::OP_AND) ? (a & b) : (op == cfa_pkg::OP_ORA) ? (a | b) :
            (op == cfa_pkg::OP_EOR) ? (a ^ b) : b;
        f[cfa_pkg::FB_V] = 1'b0;
      end
      cfa_pkg::OP_DAA: begin
        cf = flags_in[cfa_pkg::FB_C] || (a > 8'h99);
        corr[3:0] = (flags_in[cfa_pkg::FB_H] || a[3:0] > 4'h9) ? 4'h6 : 4'h0;
        corr[7:4] = cf ? 4'h6 : 4'h0;
        r = a + corr;
        f[cfa_pkg::FB_C] = cf;
      end
      cfa_pkg::OP_LSL, cfa_pkg::OP_ROL: begin
        r = {a[6:0], (op == cfa_pkg::OP_ROL) ? flags_in[cfa_pkg::FB_C] : 1'b0};
        f[cfa_pkg::FB_C] = a[7];
        f[cfa_pkg::FB_V] = r[7] ^ a[7];
      end
      cfa_pkg::OP_LSR, cfa_pkg::OP_ROR: begin
        r = {(op == cfa_pkg::OP_ROR) ? flags_in[cfa_pkg::FB_C] : 1'b0, a[7:1]};
        f[cfa_pkg::FB_C] = a[0];
        f[cfa_pkg::FB_V] = r[7] ^ a[0];
      end
      cfa_pkg::OP_BTST: f[cfa_pkg::FB_C] = a[b[2:0]];
      cfa_pkg::OP_CLC: f[cfa_pkg::FB_C] = 1'b0;
      cfa_pkg::OP_SEC: f[cfa_pkg::FB_C] = 1'b1;
      cfa_pkg::OP_CLI: f[cfa_pkg::FB_I] = 1'b0;
      cfa_pkg::OP_SEI: f[cfa_pkg::FB_I] = 1'b1;
      cfa_pkg::OP_TAP: f = a;
      cfa_pkg::OP_TPA: r = flags_in;
      default: r = a; // nop and unused codes leave flags alone
    endcase
    // negative and zero follow the 16-bit load and every operation from add to rotate right; flag transfer to accumulator leaves them
    if (op == cfa_pkg::OP_LD16) begin
      result = wide;
      f[cfa_pkg::FB_N] = wide[15];
      f[cfa_pkg::FB_Z] = (wide == 16'h0000);
      f[cfa_pkg::FB_V] = 1'b0;
    end else if (op <= cfa_pkg::OP_ROR) begin
      result = {8'h00, r};
      f[cfa_pkg::FB_N] = r[7];
      f[cfa_pkg::FB_Z] = (r == 8'h00);
    end else begin
      result = {8'h00, r};
    end
    flags_out = f | cfa_pkg::FLAGS_ONES;
  end
endmodule

/* File: cfa_addr_gen.sv */
// operand address and branch target for one addressing mode
`timescale 1ns/1ps
module cfa_addr_gen (
  input wire cfa_pkg::cfa_mode_e mode, // addressing mode
  input wire logic [15:0] pc, // opcode address
  input wire logic [7:0] byte1, // first byte after opcode
  input wire logic [7:0] byte2, // second byte after opcode
  input wire logic cond, // branch condition holds
  output logic [15:0] ea, // operand address
  output logic [15:0] target, // next instruction address
  output logic mem_access, // operand read from memory
  output logic [15:0] imm16 // assembled inline operand
);
  always_comb begin
    ea = 16'h0000;
    target = pc + cfa_pkg::LEN1;
    mem_access = 1'b0;
    imm16 = {byte1, byte2}; // high byte first
    unique case (mode)
      cfa_pkg::register_operand_mode: target = pc + cfa_pkg::LEN1;
      cfa_pkg::pc_offset_mode:
        target = pc + cfa_pkg::LEN2 + (cond ? {{8{byte1[7]}}, byte1} : 16'h0000);
      cfa_pkg::inline_operand_mode: begin
        ea = pc + cfa_pkg::LEN1;
        target = pc + cfa_pkg::LEN2;
        mem_access = 1'b1;
      end
      cfa_pkg::inline_wide_mode: begin
        ea = pc + cfa_pkg::LEN1; // high byte here, low byte next
        target = pc + cfa_pkg::LEN3;
        mem_access = 1'b1;
      end
      cfa_pkg::page_zero_mode: begin
        ea = {8'h00, byte1};
        target = pc + cfa_pkg::LEN2;
        mem_access = 1'b1;
      end
      cfa_pkg::full_address_mode: begin
        ea = {byte1, byte2};
        target = pc + cfa_pkg::LEN3;
        mem_access = 1'b1;
      end
      cfa_pkg::page_zero_branch_mode: begin
        ea = {8'h00, byte1}; // tested operand
        target = pc + cfa_pkg::LEN3 + (cond ? {{8{byte2[7]}}, byte2} : 16'h0000);
        mem_access = 1'b1;
      end
      default: target = pc + cfa_pkg::LEN1;
    endcase
  end
endmodule

/* File: cfa_core.sv */
// flag register, operation execution and operand addressing behind an axi4-lite slave
//
// Summary of operation
// - flag bits 6 and 5 always one
// - overflow bit 7 tracks signed overflow
// - half carry bit 4 on additions
// - decimal adjust corrects using half carry, carry
// - mask bit 3 blocks maskable interrupts
// - mask set after stacking, before service
// - no interrupt right after mask clear
// - negative bit 2 from result top bit
// - zero bit 1 for all-zero results
// - carry bit 0 from carry or borrow
// - bit test, shifts, rotates also drive carry
// - one linear 64-Kbyte space, 16-bit addresses
// - move source and destination modes independent
// - test branches: listed mode, implied relative target
// - register operand mode touches no memory
// - relative: signed byte offset added when taken
// - inline operand, wide one high byte first
// - page zero: high address byte is zero
// - full address read high byte first
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module cfa_core (
  input wire logic mclk, // clock
  input wire logic rst_n, // async reset
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic irq_req, // maskable interrupt request
  input wire logic stack_done, // registers pushed pulse
  output logic irq_ack // interrupt accepted, stacking
);

  ////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] flags;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [15:0] wide;
    logic [4:0] op;
    logic [15:0] result;
    logic [15:0] pc;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [2:0] src_mode;
    logic [2:0] dst_mode;
    logic cond;
    logic [2:0] csel;
    logic [15:0] src_ea;
    logic [15:0] dst_ea;
    logic [15:0] target;
    logic [15:0] imm16;
    logic src_mem;
    logic dst_mem;
    cfa_pkg::cfa_sv_e sv;
    logic inhibit;
    logic irq_ack;
  } cfa_state_s;

  cfa_state_s s;
  cfa_state_s next_s;

  ////////////////////////////////////////////////////////////////
  logic [15:0] alu_result;
  logic [7:0] alu_flags;
  logic br_cond;
  logic [15:0] src_ea;
  logic [15:0] dst_ea;
  logic [15:0] src_target;
  logic [15:0] src_imm;
  logic src_mem;
  logic dst_mem;

  // command data is fed straight from the held write so execution takes one edge
  cfa_flag_alu u_alu (
    .op(cfa_pkg::cfa_op_e'(s.wdat[4:0])),
    .a(s.opa),
    .b(s.opb),
    .wide(s.wide),
    .flags_in(s.flags),
    .result(alu_result),
    .flags_out(alu_flags)
  );

  // branch condition: explicit bit, signed, carry or not-zero tests on current flags
  always_comb begin
    unique case (s.csel)
      3'h0: br_cond = s.cond;
      3'h1: br_cond = !(s.flags[cfa_pkg::FB_Z] | (s.flags[cfa_pkg::FB_N] ^ s.flags[cfa_pkg::FB_V]));
      3'h2: br_cond = !(s.flags[cfa_pkg::FB_N] ^ s.flags[cfa_pkg::FB_V]);
      3'h3: br_cond = s.flags[cfa_pkg::FB_Z] | (s.flags[cfa_pkg::FB_N] ^ s.flags[cfa_pkg::FB_V]);
      3'h4: br_cond = s.flags[cfa_pkg::FB_N] ^ s.flags[cfa_pkg::FB_V];
      3'h5: br_cond = s.flags[cfa_pkg::FB_C];
      3'h6: br_cond = !s.flags[cfa_pkg::FB_C];
      default: br_cond = !s.flags[cfa_pkg::FB_Z];
    endcase
  end

  // two independent address units so moves can mix modes
  cfa_addr_gen u_src (
    .mode(cfa_pkg::cfa_mode_e'(s.src_mode)),
    .pc(s.pc),
    .byte1(s.b1),
    .byte2(s.b2),
    .cond(br_cond),
    .ea(src_ea),
    .target(src_target),
    .mem_access(src_mem),
    .imm16(src_imm)
  );

  // destination takes its address byte from the second fetched byte
  cfa_addr_gen u_dst (
    .mode(cfa_pkg::cfa_mode_e'(s.dst_mode)),
    .pc(s.pc),
    .byte1(s.b2),
    .byte2(8'h00),
    .cond(1'b0),
    .ea(dst_ea),
    .target(),
    .mem_access(dst_mem),
    .imm16()
  );

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  logic wr_go;
  logic exec;
  logic hit;
  logic [31:0] mw;

  always_comb begin
    next_s = s;
    wr_go = s.aw_got && s.w_got;
    exec = 1'b0;
    hit = 1'b0;
    mw = 32'h0000_0000;

    // write channel capture, either order
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.waddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdat = wdata;
      next_s.wstb = wstrb;
    end

    // write execution
    if (wr_go) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = cfa_pkg::RESP_OKAY;
      unique case (s.waddr)
        cfa_pkg::A_FLAGS: begin
          mw = merge({24'h000000, s.flags}, s.wdat, s.wstb);
          next_s.flags = mw[7:0] | cfa_pkg::FLAGS_ONES;
        end
        cfa_pkg::A_OPERAND: begin
          mw = merge({s.wide, s.opb, s.opa}, s.wdat, s.wstb);
          next_s.opa = mw[7:0];
          next_s.opb = mw[15:8];
          next_s.wide = mw[31:16];
        end
        cfa_pkg::A_COMMAND: begin
          // stacking in progress: command is answered but not run
          exec = s.wstb[0] && (s.sv == cfa_pkg::SV_RUN);
        end
        cfa_pkg::A_PC: begin
          mw = merge({16'h0000, s.pc}, s.wdat, s.wstb);
          next_s.pc = mw[15:0];
        end
        cfa_pkg::A_FETCH: begin
          mw = merge({4'h0, s.csel, s.cond, 1'b0, s.dst_mode, 1'b0, s.src_mode, s.b2, s.b1}, s.wdat, s.wstb);
          next_s.b1 = mw[7:0];
          next_s.b2 = mw[15:8];
          next_s.src_mode = mw[cfa_pkg::FF_SRC +: 3];
          next_s.dst_mode = mw[cfa_pkg::FF_DST +: 3];
          next_s.cond = mw[cfa_pkg::FF_COND];
          next_s.csel = mw[cfa_pkg::FF_CSEL +: 3];
        end
        cfa_pkg::A_RESULT, cfa_pkg::A_ADDR, cfa_pkg::A_TARGET, cfa_pkg::A_STATUS: begin
          next_s.bresp = cfa_pkg::RESP_OKAY;
        end
        default: next_s.bresp = cfa_pkg::RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    // one instruction completes, which is also an instruction boundary
    if (exec) begin
      next_s.op = s.wdat[4:0];
      next_s.result = alu_result;
      next_s.flags = alu_flags;
      // only this boundary is shielded; the next instruction's own boundary accepts again
      next_s.inhibit = s.flags[cfa_pkg::FB_I] && !alu_flags[cfa_pkg::FB_I];
      if (irq_req && !alu_flags[cfa_pkg::FB_I] &&
          !(s.flags[cfa_pkg::FB_I] && !alu_flags[cfa_pkg::FB_I])) begin
        next_s.sv = cfa_pkg::SV_STACKING;
        next_s.irq_ack = 1'b1;
      end
    end

    // mask rises only once the push is done; overrides a bus write in the same cycle
    if (s.sv == cfa_pkg::SV_STACKING && stack_done) begin
      next_s.flags[cfa_pkg::FB_I] = 1'b1;
      next_s.sv = cfa_pkg::SV_RUN;
      next_s.irq_ack = 1'b0;
    end

    // address results registered each cycle
    next_s.src_ea = src_ea;
    next_s.dst_ea = dst_ea;
    next_s.target = src_target;
    next_s.imm16 = src_imm;
    next_s.src_mem = src_mem;
    next_s.dst_mem = dst_mem;

    // read channel
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.arready = 1'b0;
      next_s.rresp = cfa_pkg::RESP_OKAY;
      hit = 1'b1;
      unique case (araddr)
        cfa_pkg::A_FLAGS: next_s.rdata = {24'h000000, s.flags | cfa_pkg::FLAGS_ONES};
        cfa_pkg::A_OPERAND: next_s.rdata = {s.wide, s.opb, s.opa};
        cfa_pkg::A_COMMAND: next_s.rdata = {27'h0000000, s.op};
        cfa_pkg::A_RESULT: next_s.rdata = {16'h0000, s.result};
        cfa_pkg::A_PC: next_s.rdata = {16'h0000, s.pc};
        cfa_pkg::A_FETCH: next_s.rdata = {4'h0, s.csel, s.cond, 1'b0, s.dst_mode, 1'b0, s.src_mode, s.b2, s.b1};
        cfa_pkg::A_ADDR: next_s.rdata = {s.dst_ea, s.src_ea};
        cfa_pkg::A_TARGET: next_s.rdata = {s.imm16, s.target};
        cfa_pkg::A_STATUS:
          next_s.rdata = {27'h0000000, s.dst_mem, s.src_mem, s.flags[cfa_pkg::FB_I], s.inhibit, s.irq_ack};
        default: begin
          hit = 1'b0;
          next_s.rdata = 32'h0000_0000;
        end
      endcase
      if (!hit) begin
        next_s.rresp = cfa_pkg::RESP_SLVERR;
      end
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // each ready only while its own channel holds nothing and no response is awaited
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
  end

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.flags <= cfa_pkg::FLAGS_RST;
      s.op <= cfa_pkg::OP_NOP;
      s.sv <= cfa_pkg::SV_RUN;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign irq_ack = s.irq_ack;

endmodule

/* File: cfa_stacker.sv */
// outside stacking logic: answers an accepted interrupt with a push-done pulse
`timescale 1ns/1ps
module cfa_stacker (
  input logic mclk, // clock
  input logic rst_n, // async reset
  input logic [3:0] delay, // cycles spent pushing
  input logic irq_ack, // stacking requested
  output logic stack_done // push finished pulse
);
  logic [3:0] cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      stack_done <= 1'b0;
    end else begin
      // one pulse per request, then idle until acknowledge drops
      stack_done <= irq_ack && !stack_done && cnt == delay;
      cnt <= (irq_ack && cnt != delay) ? cnt + 4'h1 : (irq_ack ? cnt : 4'h0);
    end
  end
endmodule

/* File: cfa_core_asserts.sv */
// concurrent checks on the ports of the flag and addressing block
`timescale 1ns/1ps
module cfa_core_asserts (
  input logic mclk, input logic rst_n, input logic [7:0] awaddr, input logic awvalid,
  input logic awready, input logic [31:0] wdata, input logic [3:0] wstrb, input logic wvalid,
  input logic wready, input logic [1:0] bresp, input logic bvalid, input logic bready,
  input logic [7:0] araddr, input logic arvalid, input logic arready, input logic [31:0] rdata,
  input logic [1:0] rresp, input logic rvalid, input logic rready, input logic irq_req,
  input logic stack_done, input logic irq_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] rd_a;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rd_a <= 8'h00;
    else if (arvalid && arready) rd_a <= araddr;
  end
  ////////////////////////////////////////////////////////////
  property p_ones; rvalid && rd_a == cfa_pkg::A_FLAGS |-> rdata[6:5] == 2'b11; endproperty
  a_ones: assert property (p_ones) else $error("fixed flag bits not one");
  property p_ack_rise; $rose(irq_ack) |-> $rose(bvalid) && $past(irq_req); endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("accept without request");
  property p_ack_hold; irq_ack && !stack_done |=> irq_ack; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("accept dropped early");
  property p_ack_drop; irq_ack && stack_done |=> !irq_ack; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("accept held after push");
  property p_mask_late; $rose(rvalid) && rd_a == cfa_pkg::A_STATUS && rdata[0] |-> !rdata[2]; endproperty
  a_mask_late: assert property (p_mask_late) else $error("mask set before push");
  property p_slverr; $rose(rvalid) && rd_a > cfa_pkg::A_STATUS |-> rresp == cfa_pkg::RESP_SLVERR && rdata == 0;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped read answered");
  property p_okay; $rose(rvalid) && rd_a <= cfa_pkg::A_STATUS && rd_a[1:0] == 2'h0 |-> rresp == 2'h0;
  endproperty
  a_okay: assert property (p_okay) else $error("mapped read refused");
  property p_rstand; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rstand: assert property (p_rstand) else $error("read data not held");
  // both channels taken at one edge: register written next edge, bvalid seen the edge after
  property p_bresp; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("write not answered");
endmodule
bind cfa_core cfa_core_asserts u_chk (.*);

/* File: cpu_flags_and_operand_addressing_bench.sv */
// self-checking bench: flags, operand addresses and interrupt acceptance
`timescale 1ns/1ps
module cpu_flags_and_operand_addressing_bench;
  logic mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, irq_req = 1'b0, awready, wready, bvalid, arready, rvalid, irq_ack, stack_done;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rnd = 32'hBC19, d;
  logic [3:0] wstrb = 4'hF, delay = 4'h1;
  logic [1:0] bresp, rresp, r;
  int n_mismatch = 0, checks = 0;
  always #20 mclk = ~mclk;
  cfa_core dut (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .irq_req(irq_req), .stack_done(stack_done), .irq_ack(irq_ack));
  cfa_stacker u_stk (.mclk(mclk), .rst_n(rst_n), .delay(delay), .irq_ack(irq_ack), .stack_done(stack_done));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // {result, flags} of one operation
  function automatic logic [15:0] alu(input logic [4:0] op, input logic [7:0] a, input logic [7:0] b,
    input logic [7:0] f);
    logic [8:0] s;
    logic [7:0] n;
    logic ci;
    n = f | 8'h60;
    ci = (op == 5'd1 || op == 5'd3) && f[0];
    case (op)
      5'd0, 5'd1: begin
        s = a + b + ci;
        n[4] = (a[3:0] + b[3:0] + ci) > 15;
        n[7] = a[7] == b[7] && s[7] != a[7];
      end
      5'd2, 5'd3: begin
        s = a - b - ci;
        n[7] = a[7] != b[7] && s[7] != a[7];
      end
      5'd5: begin s = {f[0], a & b}; n[7] = 1'b0; end
      5'd11: begin s = {a, 1'b0}; n[7] = s[7] ^ s[8]; end
      default: begin s = {f[0], b}; n[7] = 1'b0; end
    endcase
    n[2] = s[7];
    n[1] = s[7:0] == 8'h00;
    n[0] = s[8];
    return {s[7:0], n};
  endfunction
  // {operand address, next address}
  function automatic logic [31:0] adr(input logic [2:0] m, input logic [15:0] pc, input logic [7:0] b1,
    input logic [7:0] b2, input logic c);
    case (m)
      3'd1: return {16'h0, pc + 16'h2 + (c ? {{8{b1[7]}}, b1} : 16'h0)};
      3'd2: return {pc + 16'h1, pc + 16'h2};
      3'd3: return {pc + 16'h1, pc + 16'h3};
      3'd4: return {8'h00, b1, pc + 16'h2};
      3'd5: return {b1, b2, pc + 16'h3};
      3'd6: return {8'h00, b1, pc + 16'h3 + (c ? {{8{b2[7]}}, b2} : 16'h0)};
      default: return {16'h0, pc + 16'h1};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ready seen at the falling edge is what the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge mclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(negedge mclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin bready <= 1'b0; break; end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge mclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(negedge mclk);
      ta = arvalid && arready; tr = rvalid; d = rdata; r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin rready <= 1'b0; break; end
    end
  endtask
  task automatic irq(input logic [7:0] f, input logic [4:0] op, input logic ack);
    wr(cfa_pkg::A_FLAGS, {24'h0, f});
    wr(cfa_pkg::A_COMMAND, {27'h0, op});
    rd(cfa_pkg::A_STATUS);
    chk(d[0], ack);
    if (ack) begin
      chk(d[2], 1'b0);
      repeat (20) @(posedge mclk);
      rd(cfa_pkg::A_FLAGS);
      chk(d[3], 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    logic [4:0] ops [7] = '{5'd0, 5'd1, 5'd2, 5'd3, 5'd5, 5'd11, 5'd8};
    logic [15:0] e, pc;
    logic [2:0] dm;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(cfa_pkg::A_FLAGS);
    chk(d, {24'h0, cfa_pkg::FLAGS_RST});
    wr(cfa_pkg::A_FLAGS, 32'h0);
    rd(cfa_pkg::A_FLAGS);
    chk(d, 32'h60);
    for (int i = 0; i < 28; i++) begin
      rnd = lfsr(rnd);
      e = alu(ops[i % 7], rnd[7:0], rnd[15:8], rnd[23:16] | 8'h08);
      wr(cfa_pkg::A_FLAGS, {24'h0, rnd[23:16] | 8'h08});
      wr(cfa_pkg::A_OPERAND, {16'h0, rnd[15:0]});
      wr(cfa_pkg::A_COMMAND, {27'h0, ops[i % 7]});
      rd(cfa_pkg::A_FLAGS);
      chk(d[7:0], e[7:0]);
      rd(cfa_pkg::A_RESULT);
      chk(d[7:0], e[15:8]);
    end
    wr(cfa_pkg::A_OPERAND, 32'h0809);
    wr(cfa_pkg::A_COMMAND, 32'h0);
    wr(cfa_pkg::A_OPERAND, 32'h0011);
    wr(cfa_pkg::A_COMMAND, 32'hA);
    rd(cfa_pkg::A_RESULT);
    chk(d[7:0], 8'h17);
    for (int m = 0; m < 7; m++) begin
      rnd = lfsr(rnd);
      pc = rnd[31:16];
      dm = 3'(6 - m);
      wr(cfa_pkg::A_PC, {16'h0, pc});
      wr(cfa_pkg::A_FETCH, {7'h0, rnd[20], 1'b0, dm, 1'b0, 3'(m), rnd[15:0]});
      e = 16'(adr(3'(m), pc, rnd[7:0], rnd[15:8], rnd[20]));
      rd(cfa_pkg::A_TARGET);
      chk(d[15:0], e);
      chk(d[31:16], {rnd[7:0], rnd[15:8]});
      rd(cfa_pkg::A_ADDR);
      if (m > 1) chk(d[15:0], adr(3'(m), pc, rnd[7:0], rnd[15:8], 1'b0) >> 16);
      if (dm == 3'd4 || dm == 3'd5) chk(d[31:16], adr(dm, pc, rnd[15:8], 8'h00, 1'b0) >> 16);
      rd(cfa_pkg::A_STATUS);
      if (m == 0) chk(d[3], 1'b0);
    end
    // negative set, overflow clear: signed less-than holds, relative offset 0x10 taken
    wr(cfa_pkg::A_FLAGS, 32'h04);
    wr(cfa_pkg::A_FETCH, 32'h0801_0010);
    rd(cfa_pkg::A_TARGET);
    chk(d[15:0], pc + 16'h0012);
    irq_req <= 1'b1;
    irq(8'h00, 5'd22, 1'b1);
    delay <= 4'h6;
    irq(8'h08, 5'd22, 1'b0);
    irq(8'h08, 5'd18, 1'b0);
    wr(cfa_pkg::A_COMMAND, 32'd22);
    rd(cfa_pkg::A_STATUS);
    chk(d[0], 1'b1);
    repeat (20) @(posedge mclk);
    irq_req <= 1'b0;
    wr(8'h40, 32'h1);
    chk(r, cfa_pkg::RESP_SLVERR);
    rd(8'h40);
    chk(r, cfa_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    end_of_test();
  end
endmodule
